// ---- common/frame_cfg.svh ----
`ifndef FRAME_CFG_SVH
`define FRAME_CFG_SVH
// Frame and loop geometry
`define FRAME_LAST 8'h9F
`define SUB_LEN 40
`define SUB_LAST 6'h27
`define SUB_FINAL 2'h3
`define HIST_LEN 120
`define LAG_MIN 7'h28
`define LAG_MAX 7'h78
`define PULSES 6'h0D
`define PULSE_STEP 6'h03
// Parameter stream layout
`define LAR_COUNT 7'h08
`define GROUP_PARAMS 7'h11
`define LAST_PARAM 7'h4B
`define LAR_WIDTHS 24'h6E4B76
`define OFF_LAG 5'h00
`define OFF_GAIN 5'h01
`define OFF_GRID 5'h02
`define OFF_AMP 5'h03
`define OFF_PULSE0 5'h04
`define OFF_LAST 5'h10
`define W_LAG 3'h7
`define W_GAIN 3'h2
`define W_GRID 3'h2
`define W_AMP 3'h6
`define W_PULSE 3'h3
// Filter and conversion arithmetic
`define Q15_SHIFT 15
`define ALPHA_Q15 32'sh00007FDF
`define BETA_Q15 32'sh00006E14
`define SAT_MAX 32'sh00007FFF
`define SAT_MIN 32'shFFFF8000
`define R_KNEE1 32'sh00005666
`define R_KNEE2 32'sh0000799A
`define LAR_OFS1 32'sh00002B33
`define LAR_OFS2 32'sh00019800
`define DQ_MID 32'sh00000007
`define DQ_BASE 32'sh00000008
`define DQ_SHIFT 3
// Companded law handling
`define LAW_A 1'b1
`define ALAW_XOR 8'h55
`define ALAW_BIAS 13'h0020
`define MULAW_BIAS 16'h0084
`define MULAW_SCALE 3
`endif

// ---- common/frame_pkg.sv ----
package frame_pkg;
`include "frame_cfg.svh"
   // Loop stages, one-hot
   typedef enum logic [4:0] {
      ST_LAR = 5'h01,
      ST_LTP = 5'h02,
      ST_RES = 5'h04,
      ST_RPE = 5'h08,
      ST_REC = 5'h10
   } stage_t;

   // Complete state of the packer except the two-entry frame bit buffer
   typedef struct packed {
      stage_t st;
      logic [6:0] pidx;
      logic [1:0] sub;
      logic [5:0] pos;
      logic [2:0] left;
      logic [6:0] shreg;
      logic first;
      logic [6:0] lag;
      logic [1:0] gain;
      logic [1:0] grid;
      logic [5:0] amp;
      logic [12:0][2:0] pulse;
      logic [`HIST_LEN-1:0][15:0] hist;
      logic [`SUB_LEN-1:0][15:0] est;
      logic [15:0] s0_prev;
      logic [15:0] sof_prev;
      logic [7:0] cnt;
      logic pcm_ready;
      logic pre_valid;
      logic pre_first;
      logic [15:0] pre_sample;
      logic lar_valid;
      logic [15:0] lar_value;
      logic par_ready;
      logic res_ready;
      logic ltr_valid;
      logic [15:0] ltr_sample;
      logic recon_valid;
      logic [15:0] recon_sample;
   } packer_state_t;
endpackage

// ---- common/stream_if.sv ----
`timescale 1ns/100ps
interface stream_if #(parameter int W = 2);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ---- verilog/pcm_law_expand.sv ----
`timescale 1ns/100ps
`include "frame_cfg.svh"
module pcm_law_expand (
   // Companded byte and law select
   input wire logic [7:0] code,
   input wire logic law_sel,
   // Uniform result
   output logic [12:0] linear
);
   logic [7:0] c;
   logic [12:0] amag;
   logic [15:0] umag;

   // Segment expansion for either law
   always_comb begin
      c = (law_sel == `LAW_A) ? (code ^ `ALAW_XOR) : ~code;
      if (c[6:4] == 3'h0) begin
         amag = 13'({c[3:0], 1'b1});
      end else begin
         amag = (13'({c[3:0], 1'b1}) + `ALAW_BIAS) << (c[6:4] - 3'h1);
      end
      umag = ((16'({c[3:0], 3'h0}) + `MULAW_BIAS) << c[6:4]) - `MULAW_BIAS;
      if (law_sel == `LAW_A) begin
         linear = c[7] ? amag : -amag;
      end else begin
         linear = c[7] ? -13'(umag >> `MULAW_SCALE) : 13'(umag >> `MULAW_SCALE);
      end
   end
endmodule

// ---- verilog/two_entry_buffer.sv ----
`timescale 1ns/100ps
module two_entry_buffer #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Filling side
   stream_if.snk in_s,
   // Draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   typedef struct packed {
      logic [W-1:0] d0;
      logic [W-1:0] d1;
      logic v0;
      logic v1;
      logic rdy;
   } buf_state_t;

   buf_state_t s;
   buf_state_t n;

   // Pop the head, then place a new word in the first free slot
   always_comb begin
      n = s;
      if (s.v0 && out_ready) begin
         n.d0 = s.d1;
         n.v0 = s.v1;
         n.v1 = 1'b0;
      end
      if (in_s.valid && s.rdy) begin
         if (!n.v0) begin
            n.d0 = in_s.data;
            n.v0 = 1'b1;
         end else begin
            n.d1 = in_s.data;
            n.v1 = 1'b1;
         end
      end
      n.rdy = !n.v1;
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign in_s.ready = s.rdy;
   assign out_valid = s.v0;
   assign out_data = s.d0;
endmodule

// ---- verilog/speech_frame_param_packer.sv ----
`timescale 1ns/100ps
`include "frame_cfg.svh"
module speech_frame_param_packer (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Sample input
   input wire logic pcm_valid,
   input wire logic [12:0] pcm_data,
   input wire logic [7:0] pcm_code,
   input wire logic pcm_is_companded,
   input wire logic law_sel,
   output logic pcm_ready,
   // Pre-processed samples
   output logic pre_valid,
   output logic pre_first,
   output logic [15:0] pre_sample,
   // Reflection coefficients in, area ratios out
   input wire logic refl_valid,
   input wire logic [15:0] refl_coef,
   output logic lar_valid,
   output logic [15:0] lar_value,
   // Coded parameters in frame order
   input wire logic param_valid,
   input wire logic [6:0] param_value,
   output logic param_ready,
   // Short term residual in, long term residual out
   input wire logic resid_valid,
   input wire logic [15:0] resid_sample,
   output logic resid_ready,
   output logic ltr_valid,
   output logic [15:0] ltr_sample,
   // Rebuilt residual and loop position
   output logic recon_valid,
   output logic [15:0] recon_sample,
   output logic [1:0] sub_index,
   output logic [5:0] sub_pos,
   // Frame bit stream
   output logic frame_valid,
   output logic frame_bit,
   output logic frame_first,
   input wire logic frame_ready
);
   localparam logic [23:0] LAR_W = `LAR_WIDTHS;
   localparam frame_pkg::packer_state_t RESET_STATE = '{st: frame_pkg::ST_LAR, default: '0};

   frame_pkg::packer_state_t s;
   frame_pkg::packer_state_t n;
   stream_if #(.W(2)) bs ();
   logic [12:0] expanded;
   logic signed [12:0] x13;
   logic signed [15:0] sof;
   logic signed [15:0] hsel;
   logic signed [15:0] est;
   logic signed [15:0] dq;
   logic [6:0] hidx;
   logic [5:0] rel;
   logic take_par;
   logic take_res;
   logic push_ok;

   // Clamp a wide value into 16 bits
   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > `SAT_MAX) begin
         return 16'h7FFF;
      end else if (v < `SAT_MIN) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction

   // Position of a parameter inside its sub-frame group
   function automatic logic [4:0] group_off(input logic [6:0] idx);
      logic [6:0] r;
      r = idx - `LAR_COUNT;
      return 5'(r % `GROUP_PARAMS);
   endfunction

   // Bit width of the parameter at a frame index
   function automatic logic [2:0] field_width(input logic [6:0] idx);
      if (idx < `LAR_COUNT) begin
         return LAR_W[3*idx +: 3];
      end
      case (group_off(idx))
         `OFF_LAG: return `W_LAG;
         `OFF_GAIN: return `W_GAIN;
         `OFF_GRID: return `W_GRID;
         `OFF_AMP: return `W_AMP;
         default: return `W_PULSE;
      endcase
   endfunction

   // Segmented reflection to area ratio map, result in Q14
   function automatic logic signed [15:0] lar_of(input logic signed [15:0] r);
      logic signed [31:0] a;
      logic signed [31:0] m;
      a = 32'(r);
      a = (a < 0) ? -a : a;
      if (a < `R_KNEE1) begin
         m = a >>> 1;
      end else if (a < `R_KNEE2) begin
         m = a - `LAR_OFS1;
      end else begin
         m = (a <<< 2) - `LAR_OFS2;
      end
      return sat16((r < 0) ? -m : m);
   endfunction

   // Pulse code scaled by the block amplitude
   function automatic logic signed [15:0] dequant(input logic [2:0] p, input logic [5:0] a);
      logic signed [31:0] t;
      t = $signed(32'({p, 1'b0})) - `DQ_MID;
      t = (t * ($signed(32'(a[2:0])) + `DQ_BASE)) <<< a[5:3];
      return sat16(t >>> `DQ_SHIFT);
   endfunction

   pcm_law_expand u_expand (
      .code(pcm_code),
      .law_sel(law_sel),
      .linear(expanded)
   );

   two_entry_buffer #(.W(2)) u_buffer (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_s(bs),
      .out_valid(frame_valid),
      .out_data({frame_first, frame_bit}),
      .out_ready(frame_ready)
   );

   // Handshakes and serialiser output
   assign take_par = param_valid && s.par_ready;
   assign take_res = resid_valid && s.res_ready;
   assign push_ok = (s.left != 3'h0) && bs.ready;
   assign bs.valid = s.left != 3'h0;
   assign bs.data = {s.first, s.shreg[0]};

   // Loop datapath terms
   always_comb begin
      x13 = pcm_is_companded ? expanded : pcm_data;
      sof = sat16(32'(x13) - 32'($signed(s.s0_prev))
            + ((32'($signed(s.sof_prev)) * `ALPHA_Q15) >>> `Q15_SHIFT));
      hidx = s.lag - 7'(s.pos) - 7'h01;
      hsel = $signed(s.hist[hidx]);
      // Gain code zero-extended into a signed term so a negative history sample scales correctly
      est = sat16((32'(hsel) * (32'($signed({1'b0, s.gain})) + 32'sh1)) >>> 2);
      rel = s.pos - 6'(s.grid);
      dq = 16'h0000;
      if (s.pos >= 6'(s.grid) && rel % `PULSE_STEP == 6'h00 && rel / `PULSE_STEP < `PULSES) begin
         dq = dequant(s.pulse[4'(rel / `PULSE_STEP)], s.amp);
      end
   end

   // Next state
   always_comb begin
      n = s;
      n.pcm_ready = 1'b1;
      n.pre_valid = 1'b0;
      n.lar_valid = 1'b0;
      n.ltr_valid = 1'b0;
      n.recon_valid = 1'b0;
      // Pre-processing, one sample per cycle
      if (pcm_valid && s.pcm_ready) begin
         n.pre_sample = sat16(32'(sof) - ((32'($signed(s.sof_prev)) * `BETA_Q15) >>> `Q15_SHIFT));
         n.s0_prev = 16'(x13);
         n.sof_prev = sof;
         n.pre_valid = 1'b1;
         n.pre_first = s.cnt == 8'h00;
         n.cnt = (s.cnt == `FRAME_LAST) ? 8'h00 : s.cnt + 8'h01;
      end
      // Area ratio conversion
      if (refl_valid) begin
         n.lar_valid = 1'b1;
         n.lar_value = lar_of(refl_coef);
      end
      // Serialiser shifts out the low bit first
      if (push_ok) begin
         n.shreg = s.shreg >> 1;
         n.left = s.left - 3'h1;
         n.first = 1'b0;
      end
      if (take_par) begin
         n.shreg = param_value;
         n.left = field_width(s.pidx);
         n.first = s.pidx == 7'h00;
         n.pidx = (s.pidx == `LAST_PARAM) ? 7'h00 : s.pidx + 7'h01;
      end
      // Sub-frame sequencing
      case (s.st)
         frame_pkg::ST_LAR: begin
            if (take_par && s.pidx == `LAR_COUNT - 7'h01) begin
               n.st = frame_pkg::ST_LTP;
            end
         end
         frame_pkg::ST_LTP: begin
            if (take_par && group_off(s.pidx) == `OFF_LAG) begin
               n.lag = (param_value < `LAG_MIN) ? `LAG_MIN :
                       (param_value > `LAG_MAX) ? `LAG_MAX : param_value;
            end else if (take_par) begin
               n.gain = param_value[1:0];
               n.st = frame_pkg::ST_RES;
               n.pos = 6'h00;
            end
         end
         frame_pkg::ST_RES: begin
            if (take_res) begin
               n.est[s.pos] = est;
               n.ltr_sample = sat16(32'($signed(resid_sample)) - 32'(est));
               n.ltr_valid = 1'b1;
               n.pos = s.pos + 6'h01;
               if (s.pos == `SUB_LAST) begin
                  n.st = frame_pkg::ST_RPE;
                  n.pos = 6'h00;
               end
            end
         end
         frame_pkg::ST_RPE: begin
            if (take_par) begin
               case (group_off(s.pidx))
                  `OFF_GRID: n.grid = param_value[1:0];
                  `OFF_AMP: n.amp = param_value[5:0];
                  default: n.pulse[4'(group_off(s.pidx) - `OFF_PULSE0)] = param_value[2:0];
               endcase
               if (group_off(s.pidx) == `OFF_LAST) begin
                  n.st = frame_pkg::ST_REC;
                  n.pos = 6'h00;
               end
            end
         end
         frame_pkg::ST_REC: begin
            n.recon_sample = sat16(32'(dq) + 32'($signed(s.est[s.pos])));
            n.recon_valid = 1'b1;
            n.hist = {s.hist[`HIST_LEN-2:0], n.recon_sample};
            n.pos = s.pos + 6'h01;
            if (s.pos == `SUB_LAST) begin
               n.pos = 6'h00;
               n.sub = s.sub + 2'h1;
               n.st = (s.sub == `SUB_FINAL) ? frame_pkg::ST_LAR : frame_pkg::ST_LTP;
            end
         end
         default: begin
            n.st = frame_pkg::ST_LAR;
         end
      endcase
      n.par_ready = (n.left == 3'h0) && (n.st == frame_pkg::ST_LAR || n.st == frame_pkg::ST_LTP
                    || n.st == frame_pkg::ST_RPE);
      n.res_ready = n.st == frame_pkg::ST_RES;
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= RESET_STATE;
      end else begin
         s <= n;
      end
   end

   // Outputs from state
   assign pcm_ready = s.pcm_ready;
   assign pre_valid = s.pre_valid;
   assign pre_first = s.pre_first;
   assign pre_sample = s.pre_sample;
   assign lar_valid = s.lar_valid;
   assign lar_value = s.lar_value;
   assign param_ready = s.par_ready;
   assign resid_ready = s.res_ready;
   assign ltr_valid = s.ltr_valid;
   assign ltr_sample = s.ltr_sample;
   assign recon_valid = s.recon_valid;
   assign recon_sample = s.recon_sample;
   assign sub_index = s.sub;
   assign sub_pos = s.pos;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   property p_first_bit;
      take_par && s.pidx == 7'h00 |=> s.first && s.left == 3'h6 ##1 s.first != $past(bs.ready);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("frame marker not on first bit");

   property p_lar_end;
      take_par && s.pidx == 7'h07 |=> s.st == frame_pkg::ST_LTP && s.left == 3'h3 && s.pidx == 7'h08;
   endproperty
   a_lar_end: assert property (p_lar_end) else $error("area ratio fields end wrong");

   property p_lag_width;
      take_par && s.st == frame_pkg::ST_LTP && group_off(s.pidx) == 5'h00 |=> s.left == 3'h7;
   endproperty
   a_lag_width: assert property (p_lag_width) else $error("lag field not seven bits");

   property p_pulse_width;
      take_par && s.st == frame_pkg::ST_RPE && group_off(s.pidx) >= 5'h04 |=> s.left == 3'h3;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse field not three bits");

   property p_group_start;
      $changed(s.st) && s.st == frame_pkg::ST_LTP |-> s.pidx == 7'h08 + 7'(7'h11 * 7'(s.sub));
   endproperty
   a_group_start: assert property (p_group_start) else $error("group start misplaced");

   property p_lsb_first;
      take_par |=> s.shreg[0] == $past(param_value[0]) && bs.valid;
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("field not sent low bit first");

   property p_sub_len;
      take_res && s.pos == 6'h27 |=> s.st == frame_pkg::ST_RPE && !resid_ready;
   endproperty
   a_sub_len: assert property (p_sub_len) else $error("sub-frame length wrong");

   property p_ltr_out;
      take_res |=> ltr_valid ##1 !ltr_valid || $past(take_res);
   endproperty
   a_ltr_out: assert property (p_ltr_out) else $error("long term residual missing");

   property p_frame_wrap;
      pcm_valid && pcm_ready && s.cnt == 8'h9F |=> s.cnt == 8'h00 && pre_valid;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame not 160 samples");

   property p_loop_close;
      s.st == frame_pkg::ST_REC && s.pos == 6'h27 |=> recon_valid && s.pos == 6'h00 && s.st != frame_pkg::ST_REC;
   endproperty
   a_loop_close: assert property (p_loop_close) else $error("rebuild loop not closed");
endmodule

// ---- bench/frame_sink_model.sv ----
`timescale 1ns/100ps
module frame_sink_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Frame bit stream
   input wire logic frame_valid,
   input wire logic frame_bit,
   input wire logic frame_first,
   output logic frame_ready,
   // Stall control and capture
   input wire logic hold,
   output logic [259:0] cap_bits,
   output logic [259:0] cap_first,
   output logic [8:0] cap_n
);
   logic [2:0] cyc;

   // Ready drops one cycle in five and while held, so the buffer must absorb stalls
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cyc <= 3'h0;
         frame_ready <= 1'b0;
      end else begin
         cyc <= (cyc == 3'h4) ? 3'h0 : cyc + 3'h1;
         frame_ready <= !hold && (cyc != 3'h3);
      end
   end

   // Bits kept in arrival order, capture stops after the first 260
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cap_n <= 9'h000;
         cap_bits <= '0;
         cap_first <= '0;
      end else if (frame_valid && frame_ready && cap_n < 9'h104) begin
         cap_bits[cap_n] <= frame_bit;
         cap_first[cap_n] <= frame_first;
         cap_n <= cap_n + 9'h001;
      end
   end
endmodule

// ---- bench/speech_frame_param_packer_tb.sv ----
`timescale 1ns/100ps
module speech_frame_param_packer_tb;
   typedef struct {logic [15:0] coef; logic [15:0] log_area_ratio_field;} lar_row_t;
   lar_row_t rows [6] = '{'{16'h0000, 16'h0000}, '{16'h4000, 16'h2000}, '{16'hC000, 16'hE000},
      '{16'h6000, 16'h34CD}, '{16'h7C00, 16'h5800}, '{16'h8400, 16'hA800}};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic pcm_valid, pcm_is_companded, law_sel, refl_valid, param_valid, resid_valid, hold;
   logic [12:0] pcm_data;
   logic [7:0] pcm_code;
   logic [15:0] refl_coef, resid_sample, pre_sample, lar_value, ltr_sample, recon_sample, p0;
   logic [6:0] param_value;
   logic pcm_ready, pre_valid, pre_first, lar_valid, param_ready, resid_ready, ltr_valid, recon_valid;
   logic frame_valid, frame_bit, frame_first, frame_ready;
   logic [1:0] sub_index;
   logic [5:0] sub_pos;
   logic [259:0] cap_bits, cap_first, exp_bits;
   logic [8:0] cap_n;
   logic [15:0] rec_q [$];
   logic [15:0] exp_rec [40];
   int n_errors = 0;
   int cmp_count = 0;

   // Clock
   always #2.5 ref_clk = ~ref_clk;

   speech_frame_param_packer i_dut (.ref_clk, .nrst, .pcm_valid, .pcm_data, .pcm_code, .pcm_is_companded,
      .law_sel, .pcm_ready, .pre_valid, .pre_first, .pre_sample, .refl_valid, .refl_coef, .lar_valid,
      .lar_value, .param_valid, .param_value, .param_ready, .resid_valid, .resid_sample, .resid_ready,
      .ltr_valid, .ltr_sample, .recon_valid, .recon_sample, .sub_index, .sub_pos, .frame_valid,
      .frame_bit, .frame_first, .frame_ready);
   frame_sink_model i_sink (.ref_clk, .nrst, .frame_valid, .frame_bit, .frame_first, .frame_ready,
      .hold, .cap_bits, .cap_first, .cap_n);

   // Rebuilt residual collector
   always @(posedge ref_clk) begin
      if (recon_valid === 1'b1) begin
         rec_q.push_back(recon_sample);
      end
   end

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic check1(input string what, input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic check16(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_near(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if ($isunknown(seen) || $signed(seen) - $signed(exp) > 2 || $signed(exp) - $signed(seen) > 2) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Fresh reset, then one companded sample: with no history the pre-processed value is the expanded one
   task automatic law_sample(input string what, input logic [7:0] code, input logic law, input logic [15:0] exp);
      nrst = 1'b0;
      tick();
      nrst = 1'b1;
      tick();
      tick();
      pcm_is_companded = 1'b1;
      pcm_code = code;
      law_sel = law;
      pcm_valid = 1'b1;
      tick();
      {pcm_valid, pcm_is_companded, law_sel} = '0;
      check1("law pre_valid", pre_valid, 1'b1);
      check16(what, pre_sample, exp);
   endtask

   task automatic wait_ready(input bit resid);
      int n;
      n = 0;
      while ((resid ? resid_ready : param_ready) !== 1'b1 && n < 400) begin
         tick();
         n++;
      end
      check1("ready wait", n < 400, 1'b1);
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic int fw(input int i);
      int j;
      j = (i - 8) % 17;
      if (i < 8) return 6 - i / 2;
      if (j == 0) return 7;
      if (j < 3) return 2;
      if (j == 3) return 6;
      return 3;
   endfunction

   function automatic logic [6:0] fv(input int i);
      return 7'((i * 29 + 11) & ((1 << fw(i)) - 1));
   endfunction

   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("[FAIL] run expected finish seen timeout");
      give_verdict();
   end

   // Main sequence
   initial begin
      int pos, g, s, j;
      logic [5:0] a;
      logic [6:0] v;
      {pcm_valid, pcm_is_companded, law_sel, refl_valid, param_valid, resid_valid, hold} = '0;
      {pcm_data, pcm_code, refl_coef, resid_sample, param_value} = '0;
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'b1;
      tick();
      tick();
      refl_valid = 1'b1;
      foreach (rows[r]) begin
         refl_coef = rows[r].coef;
         tick();
         check1("lar_valid", lar_valid, 1'b1);
         check_near("lar_value", lar_value, rows[r].log_area_ratio_field);
      end
      refl_valid = 1'b0;
      tick();
      check1("lar_valid idle", lar_valid, 1'b0);
      $display("Test area ratio rows done");
      law_sample("mu FF", 8'hFF, 1'b0, 16'h0000);
      law_sample("mu D5", 8'hD5, 1'b0, 16'h0059);
      law_sample("mu 55", 8'h55, 1'b0, 16'hFFA7);
      law_sample("A D5", 8'hD5, 1'b1, 16'h0001);
      law_sample("A 55", 8'h55, 1'b1, 16'hFFFF);
      law_sample("A F5", 8'hF5, 1'b1, 16'h0042);
      $display("Test law expand done");
      nrst = 1'b0;
      #1 check1("pcm_ready in reset", pcm_ready, 1'b0);
      check1("param_ready in reset", param_ready, 1'b0);
      check1("frame_valid in reset", frame_valid, 1'b0);
      repeat (3) tick();
      nrst = 1'b1;
      tick();
      check1("pcm_ready after reset", pcm_ready, 1'b1);
      check1("param_ready after reset", param_ready, 1'b1);
      tick();
      $display("Test reset done");
      pcm_data = 13'h1F9C;
      pcm_valid = 1'b1;
      tick();
      check1("pre_first", pre_first, 1'b1);
      check1("pre_sample sign", pre_sample[15], 1'b1);
      p0 = pre_sample;
      tick();
      check1("pre_sample decay", $signed(pre_sample) > $signed(p0) && pre_sample[15], 1'b1);
      for (int k = 2; k < 160; k++) begin
         tick();
         check1("pre_valid", pre_valid, 1'b1);
         check1("pre_first mid", pre_first, 1'b0);
      end
      pcm_is_companded = 1'b1;
      pcm_code = 8'hFF;
      tick();
      check1("pre_first wrap", pre_first, 1'b1);
      pcm_valid = 1'b0;
      tick();
      check1("pre_valid idle", pre_valid, 1'b0);
      $display("Test samples done");
      pos = 0;
      g = fv(10);
      a = 6'(fv(11));
      foreach (exp_rec[k]) exp_rec[k] = 16'h0000;
      for (int t = 0; t < 13; t++) begin
         exp_rec[g + 3 * t] = 16'((((2 * fv(12 + t) - 7) * (8 + a[2:0])) <<< a[5:3]) >>> 3);
      end
      hold = 1'b1;
      for (int i = 0; i < 76; i++) begin
         v = fv(i);
         for (int b = 0; b < fw(i); b++) begin
            exp_bits[pos] = v[b];
            pos++;
         end
         wait_ready(1'b0);
         param_valid = 1'b1;
         param_value = fv(i);
         tick();
         param_valid = 1'b0;
         if (i == 0) begin
            repeat (20) tick();
            check1("param_ready stalled", param_ready, 1'b0);
            hold = 1'b0;
         end
         s = (i - 8) / 17;
         j = (i - 8) % 17;
         if (i >= 8 && j == 1) begin
            rec_q.delete();
            for (int k = 0; k < 40; k++) begin
               wait_ready(1'b1);
               resid_valid = 1'b1;
               resid_sample = 16'(16'h0123 + k * 97);
               tick();
               check1("ltr_valid", ltr_valid, 1'b1);
               check16("sub_index", {14'h0, sub_index}, 16'(s));
               if (k < 39) check16("sub_pos", {10'h0, sub_pos}, 16'(k + 1));
               if (s == 0) check16("ltr_sample", ltr_sample, resid_sample);
            end
            resid_valid = 1'b0;
         end
         if (i >= 8 && j == 16) begin
            for (int n = 0; n < 300 && rec_q.size() < 40; n++) tick();
            repeat (3) tick();
            check16("recon count", 16'(rec_q.size()), 16'h0028);
            if (s == 0 && rec_q.size() == 40) begin
               foreach (exp_rec[k]) check16("recon_sample", rec_q[k], exp_rec[k]);
            end
         end
      end
      for (int n = 0; n < 600 && cap_n != 9'h104; n++) tick();
      check16("frame bit count", {7'h0, cap_n}, 16'h0104);
      for (int k = 0; k < 260; k++) begin
         check1("frame bit", cap_bits[k], exp_bits[k]);
         check1("frame first", cap_first[k], k == 0);
      end
      $display("Test frame done");
      give_verdict();
   end
endmodule
